// *** bench/rsr_host.sv ***
`timescale 1ns/10ps

module rsr_host (
  // Clock
  input  wire logic       clock,
  // Command bytes to the device
  output      logic [7:0] rxData,
  output      logic       rxValid,
  input  wire logic       rxReady,
  // Response bytes from the device
  output      logic       txReady,
  // Reading pace
  input  wire logic       stall,
  input  wire logic       slow
);
  logic [2:0] pace = 3'h0;

  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
  end

  always_ff @(posedge clock) begin
    pace <= pace + 3'h1;
  end

  // Slow reader takes one byte in eight
  assign txReady = !stall && (!slow || pace == 3'h0);

  // Idle data is inverted so a stale byte never looks valid
  task automatic send_line(input logic [7:0] m[$], output logic ok);
    int n;
    ok = 1'b1;
    m.push_back(8'h0d);
    foreach (m[i]) begin
      rxData <= m[i];
      rxValid <= 1'b1;
      n = 0;
      do begin
        @(posedge clock);
        n++;
      end while (rxReady !== 1'b1 && n < 2000);
      if (rxReady !== 1'b1) ok = 1'b0;
    end
    rxValid <= 1'b0;
    rxData <= ~rxData;
  endtask : send_line
endmodule : rsr_host

// *** bench/rsr_status_asserts.sv ***
`timescale 1ns/10ps

module rsr_status_checker (
  // Clock and reset
  input wire logic                 clock,
  input wire logic                 reset_n,
  // Watched ports
  input wire logic                 cmdValid,
  input wire logic                 respValid,
  input wire logic                 respLast,
  input wire logic                 respReady,
  input wire logic [7:0]           txData,
  input wire logic                 txValid,
  input wire logic                 txReady,
  input wire rsr_pkg::rsr_cmd_s    regCmd,
  input wire rsr_pkg::rsr_event_s  events,
  input wire rsr_pkg::rsr_answer_s answer,
  input wire logic                 measReset
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // Response path
  // ------------------------------------------------------------
  sequence lastTaken;
    respValid && respReady && respLast && !events.queryFault && !events.responseLost;
  endsequence
  sequence trailerBusy;
    !respReady ##1 !respReady;
  endsequence
  a_trailer_holds_off: assert property (lastTaken |=> trailerBusy)
    else $error("response input open during trailer");
  a_tx_holds: assert property (txValid && !txReady && !events.queryFault && !events.responseLost
    |=> txValid && $stable(txData)) else $error("queued byte not held");
  a_query_flush: assert property (events.queryFault |=> !txValid) else $error("queue kept after query fault");
  a_lost_flush: assert property (events.responseLost |=> !txValid) else $error("queue kept after loss");

  // ------------------------------------------------------------
  // Register answers
  // ------------------------------------------------------------
  a_event_unused: assert property (regCmd.eventQuery |=> answer.valid && !answer.data[6] && !answer.data[1])
    else $error("event answer wrong");
  a_status_unused: assert property (regCmd.statusQuery && !regCmd.eventQuery
    |=> answer.valid && (answer.data & 8'h8b) == 8'h00) else $error("status answer wrong");
  a_status_mav: assert property (regCmd.statusQuery && !regCmd.eventQuery
    |=> answer.data[4] == $past(txValid)) else $error("message bit wrong");
  a_srv_mask_bits: assert property (regCmd.srvMaskQuery && !regCmd.eventQuery && !regCmd.statusQuery
    |=> (answer.data & 8'hcb) == 8'h00) else $error("service mask holds fixed bits");
  a_syntax_discard: assert property (events.syntaxFault |=> !cmdValid) else $error("byte shown in discard");
  a_meas_pulse: assert property (regCmd.resetCmd |=> measReset) else $error("no measurement reset");
endmodule : rsr_status_checker

bind rsr_status rsr_status_checker rsr_status_checker_i (.clock, .reset_n, .cmdValid, .respValid, .respLast,
  .respReady, .txData, .txValid, .txReady, .regCmd, .events, .answer, .measReset);

// *** bench/rsr_status_bench.sv ***
`timescale 1ns/10ps

module rsr_status_bench;
  localparam int CS = 0, RC = 1, EQ = 2, SQ = 3, SMQ = 4, EMQ = 5, ERQ = 6, SMW = 7, EMW = 8;
  logic                 clock = 1'b0, reset_n = 1'b0, cmdReady = 1'b0, drain = 1'b0, stall = 1'b0, slow = 1'b0;
  logic                 respValid = 1'b0, respLast = 1'b0, rxValid, rxReady, cmdValid, respReady, txValid;
  logic                 txReady, measReset, ok;
  logic [7:0]           respData = 8'h00, rxData, cmdData, txData, d;
  rsr_pkg::rsr_cmd_s    regCmd = '0;
  rsr_pkg::rsr_event_s  events = '0;
  rsr_pkg::rsr_answer_s answer;
  logic [31:0]          seed = 32'h3;
  logic [7:0]           expAns[$], expTx[$], expCmd[$], m[$];
  int                   failures = 0, samples_checked = 0, got;
  logic [16:0]          evTbl [6] = '{
    {9'h100, 8'h20},
    {9'h080, 8'h10},
    {9'h040, 8'h08},
    {9'h020, 8'h04},
    {9'h010, 8'h04},
    {9'h00c, 8'h01}
  };

  rsr_status rsr_status_i (.clock, .reset_n, .rxData, .rxValid, .rxReady, .cmdData, .cmdValid, .cmdReady, .respData,
    .respValid, .respLast, .respReady, .txData, .txValid, .txReady, .regCmd, .events, .answer, .measReset);
  rsr_host rsr_host_i (.clock, .rxData, .rxValid, .rxReady, .txReady, .stall, .slow);

  // ------------------------------------------------------------
  // Clock, random source, result watcher
  // ------------------------------------------------------------
  initial begin
    forever #12.5 clock = ~clock;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction : xs

  always @(posedge clock) begin
    seed <= xs(seed);
    cmdReady <= drain & seed[4];
  end

  task automatic cmp(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", nm, e, s);
    end
  endtask : cmp

  always @(posedge clock) begin
    if (answer.valid === 1'b1) cmp("answer", expAns.size() > 0 ? expAns.pop_front() : 8'hxx, answer.data);
    if (txValid === 1'b1 && txReady === 1'b1) cmp("txData", expTx.size() > 0 ? expTx.pop_front() : 8'hxx, txData);
    if (cmdValid === 1'b1 && cmdReady === 1'b1) cmp("cmdData", expCmd.size() > 0 ? expCmd.pop_front() : 8'hxx, cmdData);
  end

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (20) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
  endtask : do_reset

  task automatic rc(input int f, input logic [7:0] v);
    regCmd <= rsr_pkg::rsr_cmd_s'({9'h100 >> f, v});
    @(posedge clock);
    regCmd <= '0;
    @(posedge clock);
  endtask : rc

  task automatic q(input int f, input logic [7:0] e);
    expAns.push_back(e);
    rc(f, 8'h00);
  endtask : q

  task automatic ev(input logic [8:0] v);
    events <= rsr_pkg::rsr_event_s'(v);
    @(posedge clock);
    // Idle is a level: it must outlast the completion request by a cycle
    events <= rsr_pkg::rsr_event_s'(v & 9'h004);
    repeat (2) @(posedge clock);
  endtask : ev

  task automatic push(input logic [7:0] b, input logic last, input int bound, output logic taken);
    int n;
    respValid <= 1'b1;
    respData <= b;
    respLast <= last;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (respReady !== 1'b1 && n < bound);
    taken = respReady === 1'b1;
  endtask : push

  task automatic settle(input int bound);
    int n;
    n = 0;
    while (expTx.size() + expCmd.size() + expAns.size() > 0 && n < bound) begin
      @(posedge clock);
      n++;
    end
    if (n >= bound) cmp("pending results", 8'h00, 8'h01);
  endtask : settle

  task automatic test_done;
    $display("checks %0d, failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done

  initial begin
    repeat (90000) @(posedge clock);
    failures++;
    test_done();
  end

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    do_reset();
    q(EQ, 8'h80);
    q(EQ, 8'h00);
    q(SQ, 8'h00);
    q(EMQ, 8'h00);
    rc(SMW, 8'hff);
    q(SMQ, 8'h34);
    d = seed[7:0];
    rc(EMW, d);
    rc(RC, 8'h00);
    q(EMQ, d);
    rc(EMW, 8'hff);
    foreach (evTbl[i]) begin
      ev(evTbl[i][16:8]);
      q(SQ, 8'h60);
      q(EQ, evTbl[i][7:0]);
      q(SQ, 8'h00);
    end
    // Clearing the whole service mask keeps the master summary, and so the status answers, free of the summary edge cases
    rc(SMW, 8'h00);
    ev(9'h002);
    q(SQ, 8'h04);
    rc(ERQ, 8'h00);
    q(SQ, 8'h00);
    events.hwError <= 1'b1;
    rc(ERQ, 8'h00);
    q(SQ, 8'h04);
    rc(CS, 8'h00);
    q(SQ, 8'h04);
    events.hwError <= 1'b0;
    rc(ERQ, 8'h00);
    q(SQ, 8'h00);
    stall <= 1'b1;
    got = 0;
    ok = 1'b1;
    while (ok && got < 70) begin
      push(seed[7:0], 1'b0, 4, ok);
      if (ok) got++;
    end
    cmp("accepted bytes", 8'h40, got[7:0]);
    cmp("refused", 8'h00, {7'h00, ok});
    respValid <= 1'b0;
    @(posedge clock);
    q(SQ, 8'h10);
    rc(CS, 8'h00);
    q(SQ, 8'h10);
    ev(9'h020);
    q(EQ, 8'h04);
    q(SQ, 8'h00);
    stall <= 1'b0;
    slow <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      d = seed[7:0];
      expTx.push_back(d);
      push(d, i == 2, 50, ok);
    end
    respValid <= 1'b0;
    expTx.push_back(8'h0d);
    expTx.push_back(8'h0a);
    settle(500);
    // Lone terminator ends the discard left by the first syntax fault
    m = {};
    rsr_host_i.send_line(m, ok);
    cmp("terminator accepted", 8'h01, {7'h00, ok});
    @(posedge clock);
    m = '{8'h41, 8'h42, 8'h0a, 8'h43};
    expCmd = '{8'h43, 8'h0d};
    rsr_host_i.send_line(m, ok);
    cmp("line accepted", 8'h01, {7'h00, ok});
    ev(9'h100);
    q(EQ, 8'h20);
    drain <= 1'b1;
    settle(200);
    drain <= 1'b0;
    repeat (2) @(posedge clock);
    m = {};
    for (int i = 0; i < 1023; i++) begin
      m.push_back(i[7:0]);
      expCmd.push_back(i[7:0]);
    end
    expCmd.push_back(8'h0d);
    rsr_host_i.send_line(m, ok);
    cmp("buffer accepted", 8'h01, {7'h00, ok});
    @(posedge clock);
    cmp("rxReady", 8'h00, {7'h00, rxReady});
    drain <= 1'b1;
    settle(8000);
    rc(SMW, 8'h34);
    do_reset();
    q(EQ, 8'h80);
    q(SMQ, 8'h00);
    settle(10);
    test_done();
  end
endmodule : rsr_status_bench

// *** hdl/rsr_pkg.sv ***
package rsr_pkg;

  // ----------------------------------------------------------------
  // Queue sizes
  // ----------------------------------------------------------------
  localparam int RSR_OUTQ_DEPTH  = 64;
  localparam int RSR_INBUF_DEPTH = 1024;
  localparam int RSR_FIFO_DEPTH  = 16;
  localparam int RSR_BYTE_W      = 8;

  // ----------------------------------------------------------------
  // Status byte positions
  // ----------------------------------------------------------------
  localparam int RSR_STB_ERR_POS = 2;
  localparam int RSR_STB_MAV_POS = 4;
  localparam int RSR_STB_ESB_POS = 5;
  localparam int RSR_STB_MSS_POS = 6;

  // ----------------------------------------------------------------
  // Standard event flag positions
  // ----------------------------------------------------------------
  localparam int RSR_EVT_OPC_POS = 0;
  localparam int RSR_EVT_RQC_POS = 1;
  localparam int RSR_EVT_QYE_POS = 2;
  localparam int RSR_EVT_DDE_POS = 3;
  localparam int RSR_EVT_EXE_POS = 4;
  localparam int RSR_EVT_CME_POS = 5;
  localparam int RSR_EVT_URQ_POS = 6;
  localparam int RSR_EVT_PON_POS = 7;

  // ----------------------------------------------------------------
  // Reset values and fixed masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RSR_EVENT_FLAGS_RESET = 8'h80;
  localparam logic [7:0] RSR_SRV_MASK_RESET    = 8'h00;
  localparam logic [7:0] RSR_EVT_MASK_RESET    = 8'h00;
  localparam logic [7:0] RSR_SRV_MASK_WRITABLE = 8'h34;
  localparam logic [7:0] RSR_EVT_SETTABLE      = 8'hbd;
  localparam logic [7:0] RSR_CHAR_CR           = 8'h0d;
  localparam logic [7:0] RSR_CHAR_LF           = 8'h0a;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       clearStatus;
    logic       resetCmd;
    logic       eventQuery;
    logic       statusQuery;
    logic       srvMaskQuery;
    logic       evtMaskQuery;
    logic       errorQuery;
    logic       srvMaskWrite;
    logic       evtMaskWrite;
    logic [7:0] data;
  } rsr_cmd_s;

  typedef struct packed {
    logic syntaxFault;
    logic execFault;
    logic deviceFault;
    logic queryFault;
    logic responseLost;
    logic opcCmd;
    logic opsIdle;
    logic errorLogged;
    logic hwError;
  } rsr_event_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rsr_answer_s;

endpackage : rsr_pkg

// *** hdl/rsr_status.sv ***
`timescale 1ns/10ps

module rsr_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = rsr_pkg::RSR_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             flush,
  // Fill side
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output      logic             inReady,
  // Drain side
  output      logic [WIDTH-1:0] outData,
  output      logic             outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr_reg;
  logic [AW:0]      rdPtr_reg;
  logic             full, empty, doWrite, doRead;

  // ----------------------------------------------------------------
  // Flags
  // ----------------------------------------------------------------
  assign empty    = (wrPtr_reg == rdPtr_reg);
  assign full     = (wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]);
  assign inReady  = !full;
  assign outValid = !empty;
  assign outData  = mem[rdPtr_reg[AW-1:0]];
  assign doWrite  = inValid && !full && !flush;
  assign doRead   = outReady && !empty && !flush;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (doWrite) begin
      mem[wrPtr_reg[AW-1:0]] <= inData;
    end
  end

  // ----------------------------------------------------------------
  // Pointers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wrPtr_reg <= '0;
    end else if (flush) begin
      wrPtr_reg <= '0;
    end else if (doWrite) begin
      wrPtr_reg <= wrPtr_reg + 1'b1;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdPtr_reg <= '0;
    end else if (flush) begin
      rdPtr_reg <= '0;
    end else if (doRead) begin
      rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end

endmodule : rsr_fifo

module rsr_status #(
  parameter int OUTQ_DEPTH  = rsr_pkg::RSR_OUTQ_DEPTH,
  parameter int INBUF_DEPTH = rsr_pkg::RSR_INBUF_DEPTH
) (
  // Clock and reset
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  // Incoming command bytes from transport
  input  wire logic [7:0]           rxData,
  input  wire logic                 rxValid,
  output      logic                 rxReady,
  // Command bytes to the parser
  output      logic [7:0]           cmdData,
  output      logic                 cmdValid,
  input  wire logic                 cmdReady,
  // Response text from the formatter
  input  wire logic [7:0]           respData,
  input  wire logic                 respValid,
  input  wire logic                 respLast,
  output      logic                 respReady,
  // Response bytes to transport
  output      logic [7:0]           txData,
  output      logic                 txValid,
  input  wire logic                 txReady,
  // Register commands and instrument events
  input  wire rsr_pkg::rsr_cmd_s    regCmd,
  input  wire rsr_pkg::rsr_event_s  events,
  // Register answers and measurement reset
  output      rsr_pkg::rsr_answer_s answer,
  output      logic                 measReset
);

  typedef enum logic [1:0] {
    TERM_IDLE,
    TERM_CR,
    TERM_LF
  } rsr_term_e;

  rsr_term_e  termState_reg;
  logic [7:0] eventFlags_reg;
  logic [7:0] evtMask_reg;
  logic [7:0] srvMask_reg;
  logic [7:0] evtEnabledPrev_reg;
  logic [7:0] stbEnabledPrev_reg;
  logic [7:0] eventFlags_next, evtEnabled, stbEnabled, eventSet, statusByte, bufData, pushData;
  logic       esbLatch_reg;
  logic       mssLatch_reg;
  logic       errPending_reg;
  logic       opcPending_reg;
  logic       discard_reg;
  logic       eventSummary, masterSummary, bufValid, bufPop, termPop, outFlush, pushValid, pushReady;

  // ----------------------------------------------------------------
  // Command input buffer
  // ----------------------------------------------------------------
  rsr_fifo #(
    .WIDTH (rsr_pkg::RSR_BYTE_W),
    .DEPTH (INBUF_DEPTH)
  ) inputBuffer (
    .clock    (clock),
    .reset_n  (reset_n),
    .flush    (1'b0),
    .inData   (rxData),
    .inValid  (rxValid),
    .inReady  (rxReady),
    .outData  (bufData),
    .outValid (bufValid),
    .outReady (bufPop)
  );

  // Discarded bytes are drained without waiting on the parser
  assign cmdData  = bufData;
  assign cmdValid = bufValid && !discard_reg;
  assign bufPop   = discard_reg ? bufValid : cmdReady;
  assign termPop  = discard_reg && bufValid &&
                    (bufData == rsr_pkg::RSR_CHAR_CR || bufData == rsr_pkg::RSR_CHAR_LF);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      discard_reg <= 1'b0;
    end else begin
      discard_reg <= events.syntaxFault || (discard_reg && !termPop);
    end
  end

  // ----------------------------------------------------------------
  // Response output queue
  // ----------------------------------------------------------------
  assign outFlush  = events.queryFault || events.responseLost;
  assign pushValid = (termState_reg == TERM_IDLE) ? respValid : 1'b1;
  assign pushData  = (termState_reg == TERM_IDLE) ? respData :
                     (termState_reg == TERM_CR) ? rsr_pkg::RSR_CHAR_CR : rsr_pkg::RSR_CHAR_LF;
  // Formatter waits while full or while the terminator is queued
  assign respReady = (termState_reg == TERM_IDLE) && pushReady && !outFlush;

  rsr_fifo #(
    .WIDTH (rsr_pkg::RSR_BYTE_W),
    .DEPTH (OUTQ_DEPTH)
  ) outputQueue (
    .clock    (clock),
    .reset_n  (reset_n),
    .flush    (outFlush),
    .inData   (pushData),
    .inValid  (pushValid),
    .inReady  (pushReady),
    .outData  (txData),
    .outValid (txValid),
    .outReady (txReady)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      termState_reg <= TERM_IDLE;
    end else if (outFlush) begin
      termState_reg <= TERM_IDLE;
    end else begin
      case (termState_reg)
        TERM_IDLE: termState_reg <= (respValid && respReady && respLast) ? TERM_CR : TERM_IDLE;
        TERM_CR:   termState_reg <= pushReady ? TERM_LF : TERM_CR;
        TERM_LF:   termState_reg <= pushReady ? TERM_IDLE : TERM_LF;
        default:   termState_reg <= TERM_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Standard event flags
  // ----------------------------------------------------------------
  always_comb begin
    eventSet = 8'h00;
    eventSet[rsr_pkg::RSR_EVT_CME_POS] = events.syntaxFault;
    eventSet[rsr_pkg::RSR_EVT_EXE_POS] = events.execFault;
    eventSet[rsr_pkg::RSR_EVT_DDE_POS] = events.deviceFault;
    eventSet[rsr_pkg::RSR_EVT_QYE_POS] = events.queryFault || events.responseLost;
    eventSet[rsr_pkg::RSR_EVT_OPC_POS] = opcPending_reg && events.opsIdle;
    eventSet = eventSet & rsr_pkg::RSR_EVT_SETTABLE;
  end

  // A fresh event in the clearing cycle survives the clear
  assign eventFlags_next = ((regCmd.clearStatus || regCmd.eventQuery) ? 8'h00 : eventFlags_reg) |
                           eventSet;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      eventFlags_reg <= rsr_pkg::RSR_EVENT_FLAGS_RESET;
    end else begin
      eventFlags_reg <= eventFlags_next;
    end
  end

  // Completion counts only once every earlier message has run
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      opcPending_reg <= 1'b0;
    end else if (events.opcCmd) begin
      opcPending_reg <= 1'b1;
    end else if (events.opsIdle) begin
      opcPending_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Enable masks
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      evtMask_reg <= rsr_pkg::RSR_EVT_MASK_RESET;
    end else if (regCmd.evtMaskWrite) begin
      evtMask_reg <= regCmd.data;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      srvMask_reg <= rsr_pkg::RSR_SRV_MASK_RESET;
    end else if (regCmd.srvMaskWrite) begin
      srvMask_reg <= regCmd.data & rsr_pkg::RSR_SRV_MASK_WRITABLE;
    end
  end

  // ----------------------------------------------------------------
  // Error pending
  // ----------------------------------------------------------------
  // Hardware error holds the bit through both clears
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      errPending_reg <= 1'b0;
    end else begin
      errPending_reg <= events.errorLogged || events.hwError ||
                        (errPending_reg && !regCmd.errorQuery && !regCmd.clearStatus);
    end
  end

  // ----------------------------------------------------------------
  // Summary bits
  // ----------------------------------------------------------------
  // Combinational so a mask write shows in the next cycle, as soon as the mask register loads
  assign evtEnabled   = eventFlags_reg & evtMask_reg;
  assign eventSummary = (|(evtEnabled & ~evtEnabledPrev_reg)) ||
                        (esbLatch_reg && (|evtEnabled));

  always_comb begin
    statusByte = 8'h00;
    statusByte[rsr_pkg::RSR_STB_ERR_POS] = errPending_reg;
    statusByte[rsr_pkg::RSR_STB_MAV_POS] = txValid;
    statusByte[rsr_pkg::RSR_STB_ESB_POS] = eventSummary;
    statusByte[rsr_pkg::RSR_STB_MSS_POS] = masterSummary;
  end

  assign stbEnabled    = {1'b0, 1'b0, eventSummary, txValid, 1'b0, errPending_reg, 2'b00} & srvMask_reg;
  assign masterSummary = (|(stbEnabled & ~stbEnabledPrev_reg)) ||
                         (mssLatch_reg && (|stbEnabled));

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      evtEnabledPrev_reg <= 8'h00;
      esbLatch_reg       <= 1'b0;
    end else begin
      evtEnabledPrev_reg <= evtEnabled;
      esbLatch_reg       <= eventSummary;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stbEnabledPrev_reg <= 8'h00;
      mssLatch_reg       <= 1'b0;
    end else begin
      stbEnabledPrev_reg <= stbEnabled;
      mssLatch_reg       <= masterSummary;
    end
  end

  // ----------------------------------------------------------------
  // Query answers
  // ----------------------------------------------------------------
  // One query per cycle; the parser serialises them
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      answer <= '0;
    end else begin
      answer.valid <= regCmd.eventQuery || regCmd.statusQuery ||
                      regCmd.srvMaskQuery || regCmd.evtMaskQuery;
      if (regCmd.eventQuery) begin
        answer.data <= eventFlags_reg;
      end else if (regCmd.statusQuery) begin
        answer.data <= statusByte;
      end else if (regCmd.srvMaskQuery) begin
        answer.data <= srvMask_reg;
      end else if (regCmd.evtMaskQuery) begin
        answer.data <= evtMask_reg;
      end
    end
  end

  // ----------------------------------------------------------------
  // Reset command
  // ----------------------------------------------------------------
  // Status, masks and queues stay; only measurement settings go
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      measReset <= 1'b0;
    end else begin
      measReset <= regCmd.resetCmd;
    end
  end

endmodule : rsr_status
